// ==== common/dav_map.vh ====
// register indices, field positions, reset values and timing figures of the integrator
`ifndef DAV_MAP_VH
`define DAV_MAP_VH

// register indices; byte address is four times the index
`define DAV_IDX_X_ANG_LO      8'h24
`define DAV_IDX_X_ANG_HI      8'h26
`define DAV_IDX_Y_ANG_LO      8'h28
`define DAV_IDX_Y_ANG_HI      8'h2a
`define DAV_IDX_Z_ANG_LO      8'h2c
`define DAV_IDX_Z_ANG_HI      8'h2e
`define DAV_IDX_X_VEL_LO      8'h30
`define DAV_IDX_X_VEL_HI      8'h32
`define DAV_IDX_DECIMATION    8'h60
`define DAV_IDX_CONTROL       8'h62
`define DAV_IDX_UPDATE_COUNT  8'h64

// byte address width of the register slave
`define DAV_ADDR_W            10

// control register fields
`define DAV_CTRL_EXT_SAMPLE   0

// reset values
`define DAV_DECIMATION_RST    16'h0000
`define DAV_CONTROL_RST       1'b0
`define DAV_UNMAPPED_READ     32'h0000_0000

// timing: system clock and nominal internal sample rate
`define DAV_CLK_HZ            200000000
`define DAV_SAMPLE_SPS        2000
`define DAV_SAMPLE_DIV        (`DAV_CLK_HZ / `DAV_SAMPLE_SPS)

// full-scale delta angle of the widest model, degrees
`define DAV_FS_DEG_WIDEST     2160

`endif

// ==== hw/dav_axis_integ.v ====
// one axis of trapezoidal integration with scaling and 32-bit saturation
`timescale 1ns/1ps
module dav_axis_integ #(
	parameter IN_W  = 16,
	parameter ACC_W = 40,
	parameter MUL_W = 8,
	parameter SHIFT = 0
) (
	input  wire                    clk,
	input  wire                    rst_n,
	input  wire                    sample_en,
	input  wire                    last,
	input  wire signed [IN_W-1:0]  sample_in,
	input  wire        [MUL_W-1:0] gain,
	output reg         [31:0]      result_q
);
	localparam PW = ACC_W + MUL_W + 1;

	reg  signed [IN_W-1:0]  prev_q;
	reg  signed [ACC_W-1:0] acc_q;
	wire signed [IN_W:0]    pair;
	wire signed [ACC_W-1:0] pair_ext;
	wire signed [ACC_W-1:0] total;
	wire signed [PW-1:0]    prod;
	wire signed [PW-1:0]    scaled;
	wire        [PW-32:0]   top_bits;
	wire                    in_range;
	wire        [31:0]      sat;

	// current sample plus its predecessor, one trapezoid pair
	assign pair     = {sample_in[IN_W-1], sample_in} + {prev_q[IN_W-1], prev_q};
	assign pair_ext = {{(ACC_W-IN_W-1){pair[IN_W]}}, pair};
	assign total    = acc_q + pair_ext;
	// gain folds 1/(2*fs) and the full-scale weight into one constant
	assign prod     = total * $signed({1'b0, gain});
	assign scaled   = prod >>> SHIFT;
	// clamp to the 32-bit twos complement code range
	assign top_bits = scaled[PW-1:31];
	assign in_range = (&top_bits) | ~(|top_bits);
	assign sat      = in_range ? scaled[31:0]
		: (scaled[PW-1] ? 32'h8000_0000 : 32'h7fff_ffff);

	// accumulate pairs; close the period on the last sample
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			prev_q   <= {IN_W{1'b0}};
			acc_q    <= {ACC_W{1'b0}};
			result_q <= 32'h0000_0000;
		end else if (sample_en) begin
			prev_q <= sample_in;
			if (last) begin
				acc_q    <= {ACC_W{1'b0}};
				result_q <= sat;
			end else begin
				acc_q <= total;
			end
		end
	end
endmodule

// ==== hw/dav_top.v ====
// delta angle and delta velocity integrator with its avalon-mm register slave
//
// How it works
// - velocity: sum of accel pairs over 2fs
// - decimation setting plus one samples per output
// - internal sample clock nominally 2000 per second
// - velocity split into high and low words
// - angle high word twos complement, zero is zero
// - x angle low 0x24, high 0x26
// - y angle low 0x28, high 0x2a
// - z angle low 0x2c, high 0x2e
// - 16-bit codes 0x7fff down to 0x8000
// - 32-bit codes 0x7fffffff down to 0x80000000
// - velocity high word, plus minus 400 m/s
// - x velocity low 0x30, high 0x32
// - angle full scale set by model variant
//
// Design decision made here: the Avalon-MM register port.
`timescale 1ns/1ps
`include "dav_map.vh"
module dav_top #(
	parameter SAMPLE_DIV = `DAV_SAMPLE_DIV,
	parameter FS_DEG     = 360,
	parameter ANG_GAIN   = 1,
	parameter ANG_SHIFT  = 0,
	parameter VEL_GAIN   = 1,
	parameter VEL_SHIFT  = 0,
	parameter IN_W       = 16,
	parameter ACC_W      = 40,
	parameter DEC_W      = 16
) (
	input  wire                     sys_clk,
	input  wire                     rst_n,
	input  wire [`DAV_ADDR_W-1:0]   avs_address,
	input  wire                     avs_read,
	input  wire                     avs_write,
	input  wire [31:0]              avs_writedata,
	input  wire [3:0]               avs_byteenable,
	output reg  [31:0]              avs_readdata,
	output reg                      avs_waitrequest,
	input  wire                     ext_sample_pin,
	input  wire [IN_W-1:0]          rate_x,
	input  wire [IN_W-1:0]          rate_y,
	input  wire [IN_W-1:0]          rate_z,
	input  wire [IN_W-1:0]          accel_x,
	output reg                      sample_done_pin
);
	// gain per model: narrower full scale gives more counts per degree
	localparam MUL_W        = 8;
	localparam ANG_MUL_INT  = ANG_GAIN * (`DAV_FS_DEG_WIDEST / FS_DEG);
	localparam [MUL_W-1:0] ANG_MUL = ANG_MUL_INT[MUL_W-1:0];
	localparam [MUL_W-1:0] VEL_MUL = VEL_GAIN[MUL_W-1:0];
	localparam [31:0] DIV_LAST = SAMPLE_DIV - 1;

	// byte addresses derived from register indices
	localparam [`DAV_ADDR_W-1:0] A_X_ANG_LO = {`DAV_IDX_X_ANG_LO, 2'b00};
	localparam [`DAV_ADDR_W-1:0] A_X_ANG_HI = {`DAV_IDX_X_ANG_HI, 2'b00};
	localparam [`DAV_ADDR_W-1:0] A_Y_ANG_LO = {`DAV_IDX_Y_ANG_LO, 2'b00};
	localparam [`DAV_ADDR_W-1:0] A_Y_ANG_HI = {`DAV_IDX_Y_ANG_HI, 2'b00};
	localparam [`DAV_ADDR_W-1:0] A_Z_ANG_LO = {`DAV_IDX_Z_ANG_LO, 2'b00};
	localparam [`DAV_ADDR_W-1:0] A_Z_ANG_HI = {`DAV_IDX_Z_ANG_HI, 2'b00};
	localparam [`DAV_ADDR_W-1:0] A_X_VEL_LO = {`DAV_IDX_X_VEL_LO, 2'b00};
	localparam [`DAV_ADDR_W-1:0] A_X_VEL_HI = {`DAV_IDX_X_VEL_HI, 2'b00};
	localparam [`DAV_ADDR_W-1:0] A_DEC      = {`DAV_IDX_DECIMATION, 2'b00};
	localparam [`DAV_ADDR_W-1:0] A_CTRL     = {`DAV_IDX_CONTROL, 2'b00};
	localparam [`DAV_ADDR_W-1:0] A_COUNT    = {`DAV_IDX_UPDATE_COUNT, 2'b00};

	// bus access states
	localparam [1:0] BUS_IDLE = 2'd0;
	localparam [1:0] BUS_ACK  = 2'd1;
	localparam [1:0] BUS_DONE = 2'd2;

	reg  [31:0]       div_q;
	reg               div_tick_q;
	reg               pin_meta_q;
	reg               pin_sync_q;
	reg               pin_prev_q;
	reg               ext_tick_q;
	reg  [DEC_W-1:0]  decimation_q;
	reg  [DEC_W-1:0]  dec_active_q;
	reg  [DEC_W-1:0]  dec_cnt_q;
	reg               ext_sel_q;
	reg  [15:0]       update_count_q;
	reg  [1:0]        bus_state_q;
	reg  [31:0]       rd_d;
	wire              sample_en;
	wire              period_last;
	wire [31:0]       x_ang;
	wire [31:0]       y_ang;
	wire [31:0]       z_ang;
	wire [31:0]       x_vel;
	wire              wr_take;

	// internal sample clock: one enable pulse per sample period
	always @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			div_q      <= 32'h0000_0000;
			div_tick_q <= 1'b0;
		end else if (div_q >= DIV_LAST) begin
			div_q      <= 32'h0000_0000;
			div_tick_q <= 1'b1;
		end else begin
			div_q      <= div_q + 32'h0000_0001;
			div_tick_q <= 1'b0;
		end
	end

	// external sample pin: two flops, then rising edge detect
	always @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			pin_meta_q <= 1'b0;
			pin_sync_q <= 1'b0;
			pin_prev_q <= 1'b0;
			ext_tick_q <= 1'b0;
		end else begin
			pin_meta_q <= ext_sample_pin;
			pin_sync_q <= pin_meta_q;
			pin_prev_q <= pin_sync_q;
			ext_tick_q <= pin_sync_q & ~pin_prev_q;
		end
	end

	// choose the sample source; the pin path is only for an outside clock
	assign sample_en = ext_sel_q ? ext_tick_q : div_tick_q;

	// last sample of a period; >= keeps a lowered setting from overrunning
	assign period_last = (dec_cnt_q >= dec_active_q);

	// decimation counter; new setting takes hold only at a period boundary
	always @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			dec_cnt_q    <= {DEC_W{1'b0}};
			dec_active_q <= `DAV_DECIMATION_RST;
		end else if (sample_en) begin
			if (period_last) begin
				dec_cnt_q    <= {DEC_W{1'b0}};
				dec_active_q <= decimation_q;
			end else begin
				dec_cnt_q <= dec_cnt_q + {{(DEC_W-1){1'b0}}, 1'b1};
			end
		end
	end

	// rotation axes share the model-dependent gain
	dav_axis_integ #(
		.IN_W  (IN_W),
		.ACC_W (ACC_W),
		.MUL_W (MUL_W),
		.SHIFT (ANG_SHIFT)
	) u_x_ang (
		.clk       (sys_clk),
		.rst_n     (rst_n),
		.sample_en (sample_en),
		.last      (period_last),
		.sample_in (rate_x),
		.gain      (ANG_MUL),
		.result_q  (x_ang)
	);

	dav_axis_integ #(
		.IN_W  (IN_W),
		.ACC_W (ACC_W),
		.MUL_W (MUL_W),
		.SHIFT (ANG_SHIFT)
	) u_y_ang (
		.clk       (sys_clk),
		.rst_n     (rst_n),
		.sample_en (sample_en),
		.last      (period_last),
		.sample_in (rate_y),
		.gain      (ANG_MUL),
		.result_q  (y_ang)
	);

	dav_axis_integ #(
		.IN_W  (IN_W),
		.ACC_W (ACC_W),
		.MUL_W (MUL_W),
		.SHIFT (ANG_SHIFT)
	) u_z_ang (
		.clk       (sys_clk),
		.rst_n     (rst_n),
		.sample_en (sample_en),
		.last      (period_last),
		.sample_in (rate_z),
		.gain      (ANG_MUL),
		.result_q  (z_ang)
	);

	// linear axis: weight chosen for a 400 m/s full scale
	dav_axis_integ #(
		.IN_W  (IN_W),
		.ACC_W (ACC_W),
		.MUL_W (MUL_W),
		.SHIFT (VEL_SHIFT)
	) u_x_vel (
		.clk       (sys_clk),
		.rst_n     (rst_n),
		.sample_en (sample_en),
		.last      (period_last),
		.sample_in (accel_x),
		.gain      (VEL_MUL),
		.result_q  (x_vel)
	);

	// data update marker and counter, same edge as the result registers
	always @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			sample_done_pin <= 1'b0;
			update_count_q  <= 16'h0000;
		end else begin
			sample_done_pin <= sample_en & period_last;
			if (sample_en & period_last) begin
				update_count_q <= update_count_q + 16'h0001;
			end
		end
	end

	// a request is served once, on the cycle the slave is idle
	assign wr_take = (bus_state_q == BUS_IDLE) & avs_write & ~avs_read;

	// read decode; both halves come from registers loaded together
	always @* begin
		if (avs_address == A_X_ANG_LO) begin
			rd_d = {16'h0000, x_ang[15:0]};
		end else if (avs_address == A_X_ANG_HI) begin
			rd_d = {16'h0000, x_ang[31:16]};
		end else if (avs_address == A_Y_ANG_LO) begin
			rd_d = {16'h0000, y_ang[15:0]};
		end else if (avs_address == A_Y_ANG_HI) begin
			rd_d = {16'h0000, y_ang[31:16]};
		end else if (avs_address == A_Z_ANG_LO) begin
			rd_d = {16'h0000, z_ang[15:0]};
		end else if (avs_address == A_Z_ANG_HI) begin
			rd_d = {16'h0000, z_ang[31:16]};
		end else if (avs_address == A_X_VEL_LO) begin
			rd_d = {16'h0000, x_vel[15:0]};
		end else if (avs_address == A_X_VEL_HI) begin
			rd_d = {16'h0000, x_vel[31:16]};
		end else if (avs_address == A_DEC) begin
			rd_d = {{(32-DEC_W){1'b0}}, decimation_q};
		end else if (avs_address == A_CTRL) begin
			rd_d = {31'h0000_0000, ext_sel_q};
		end else if (avs_address == A_COUNT) begin
			rd_d = {16'h0000, update_count_q};
		end else begin
			rd_d = `DAV_UNMAPPED_READ;
		end
	end

	// avalon handshake: waitrequest drops for one cycle per request
	always @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			bus_state_q     <= BUS_IDLE;
			avs_waitrequest <= 1'b1;
			avs_readdata    <= 32'h0000_0000;
		end else begin
			case (bus_state_q)
				BUS_IDLE: begin
					if (avs_read | avs_write) begin
						bus_state_q     <= BUS_ACK;
						avs_waitrequest <= 1'b0;
						if (avs_read) begin
							avs_readdata <= rd_d;
						end
					end
				end
				BUS_ACK: begin
					// master samples the answer here and releases
					bus_state_q     <= BUS_DONE;
					avs_waitrequest <= 1'b1;
				end
				default: begin
					// one idle cycle guards against a held request
					bus_state_q <= BUS_IDLE;
				end
			endcase
		end
	end

	// writable settings; output words are read-only, writes there are dropped
	always @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			decimation_q <= `DAV_DECIMATION_RST;
			ext_sel_q    <= `DAV_CONTROL_RST;
		end else if (wr_take) begin
			if (avs_address == A_DEC) begin
				if (avs_byteenable[0]) begin
					decimation_q[7:0] <= avs_writedata[7:0];
				end
				if (avs_byteenable[1]) begin
					decimation_q[DEC_W-1:8] <= avs_writedata[DEC_W-1:8];
				end
			end else if (avs_address == A_CTRL) begin
				if (avs_byteenable[0]) begin
					ext_sel_q <= avs_writedata[`DAV_CTRL_EXT_SAMPLE];
				end
			end
		end
	end
endmodule

// ==== tb/dav_host_bfm.sv ====
// host model issuing avalon-mm transfers to the integrator registers
`timescale 1ns/1ps
module dav_host_bfm (
	input  wire         sys_clk,
	output logic [9:0]  avs_address,
	output logic        avs_read,
	output logic        avs_write,
	output logic [31:0] avs_writedata,
	output wire  [3:0]  avs_byteenable,
	input  wire  [31:0] avs_readdata,
	input  wire         avs_waitrequest
);
	// all registers are 16-bit words in the low lanes
	assign avs_byteenable = 4'h3;

	// idle bus at time zero
	initial begin
		avs_address   = 10'h3ff;
		avs_read      = 1'b0;
		avs_write     = 1'b0;
		avs_writedata = 32'h0;
	end

	// one transfer, held until waitrequest is sampled low
	task automatic xfer(input logic wr, input logic [9:0] a, input logic [31:0] wd,
		output logic [31:0] rd);
		@(posedge sys_clk);
		avs_address   <= a;
		avs_read      <= !wr;
		avs_write     <= wr;
		avs_writedata <= wd;
		do @(posedge sys_clk); while (avs_waitrequest !== 1'b0);
		rd = avs_readdata;
		avs_read  <= 1'b0;
		avs_write <= 1'b0;
		// released lines show the inverse so stale values cannot pass
		avs_address   <= ~a;
		avs_writedata <= ~wd;
	endtask
endmodule

// ==== tb/dav_top_chk.sv ====
// concurrent checks on the integrator register bus and sample-done pin
`timescale 1ns/1ps
module dav_top_chk #(
	parameter SAMPLE_DIV = 8
) (
	input wire        sys_clk,
	input wire        rst_n,
	input wire [9:0]  avs_address,
	input wire        avs_read,
	input wire        avs_write,
	input wire [31:0] avs_readdata,
	input wire        avs_waitrequest,
	input wire        ext_sample_pin,
	input wire        sample_done_pin
);
	logic [19:0] gap_q;
	logic        seen_q;

	// cycles since the last pulse; the first pulse only arms the grid check
	// pin activity disarms it, pin edges fall off the internal grid
	always @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			gap_q  <= 20'h0;
			seen_q <= 1'b0;
		end else if (ext_sample_pin) begin
			gap_q  <= 20'h0;
			seen_q <= 1'b0;
		end else if (sample_done_pin) begin
			gap_q  <= 20'h0;
			seen_q <= 1'b1;
		end else begin
			gap_q <= gap_q + 20'h1;
		end
	end

	default clocking @(posedge sys_clk); endclocking
	default disable iff (!rst_n);

	// slave answer comes a few cycles after a request is raised
	sequence s_answer;
		##[0:3] !avs_waitrequest;
	endsequence

	property p_wait_one;
		!avs_waitrequest |=> avs_waitrequest;
	endproperty
	property p_answer;
		(avs_read || avs_write) |-> s_answer;
	endproperty
	property p_upper_zero;
		avs_read && !avs_waitrequest |-> avs_readdata[31:16] == 16'h0000;
	endproperty
	property p_unmapped;
		avs_read && !avs_waitrequest && (avs_address < 10'h090 || avs_address > 10'h190)
			|-> avs_readdata == 32'h0000_0000;
	endproperty
	property p_pulse_one;
		sample_done_pin |=> !sample_done_pin;
	endproperty
	property p_pulse_grid;
		sample_done_pin && seen_q |-> ((gap_q + 20'h1) % SAMPLE_DIV) == 0;
	endproperty
	property p_rd_hold;
		!(avs_read && !avs_waitrequest) |-> $stable(avs_readdata);
	endproperty
	property p_idle_wait;
		!avs_read && !avs_write && $past(!avs_read && !avs_write) |-> avs_waitrequest;
	endproperty

	a_wait_one: assert property (p_wait_one) else $error("waitrequest low too long");
	a_answer: assert property (p_answer) else $error("request not answered");
	a_upper_zero: assert property (p_upper_zero) else $error("upper read half not zero");
	a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
	a_pulse_one: assert property (p_pulse_one) else $error("sample done pulse too long");
	a_pulse_grid: assert property (p_pulse_grid) else $error("update off sample grid");
	a_rd_hold: assert property (p_rd_hold) else $error("readdata moved outside read");
	a_idle_wait: assert property (p_idle_wait) else $error("answer without request");
endmodule

// ==== tb/tb_top.sv ====
// testbench for the delta angle and delta velocity integrator
`timescale 1ns/1ps
`include "dav_map.vh"
module tb_top;
	logic        sys_clk = 1'b0;
	logic        rst_n = 1'b0;
	logic        ext_sample_pin = 1'b0;
	logic [15:0] rate_x = 16'h0;
	logic [15:0] rate_y = 16'h0;
	logic [15:0] rate_z = 16'h0;
	logic [15:0] accel_x = 16'h0;
	wire         sample_done_pin;
	wire  [9:0]  avs_address;
	wire         avs_read;
	wire         avs_write;
	wire  [31:0] avs_writedata;
	wire  [3:0]  avs_byteenable;
	wire  [31:0] avs_readdata;
	wire         avs_waitrequest;
	int          miscompares = 0;
	int          compares = 0;
	logic [31:0] d;
	logic [31:0] c0;

	// 200 mhz
	always #2.5 sys_clk = ~sys_clk;

	// short divider keeps runs brief; gain 42*6 lets saturation show within 200 samples
	dav_top #(.SAMPLE_DIV(8), .ANG_GAIN(42)) dav_top_inst (
		.sys_clk(sys_clk), .rst_n(rst_n), .avs_address(avs_address), .avs_read(avs_read),
		.avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
		.avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
		.ext_sample_pin(ext_sample_pin), .rate_x(rate_x), .rate_y(rate_y), .rate_z(rate_z),
		.accel_x(accel_x), .sample_done_pin(sample_done_pin));

	dav_host_bfm dav_host_bfm_inst (
		.sys_clk(sys_clk), .avs_address(avs_address), .avs_read(avs_read),
		.avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
		.avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest));

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		compares++;
		if (seen !== exp) begin
			miscompares++;
			$display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic summarize;
		$display("compares %0d miscompares %0d", compares, miscompares);
		if (miscompares == 0 && compares > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask

	task automatic rd(input logic [7:0] idx, output logic [31:0] v);
		dav_host_bfm_inst.xfer(1'b0, {idx, 2'b00}, 32'h0, v);
	endtask

	task automatic wr(input logic [7:0] idx, input logic [31:0] v);
		logic [31:0] unused;
		dav_host_bfm_inst.xfer(1'b1, {idx, 2'b00}, v, unused);
	endtask

	// waits for one update pulse, bounded, then lets it pass
	task automatic wait_done;
		int n;
		n = 0;
		while (sample_done_pin !== 1'b1 && n < 5000) begin
			@(posedge sys_clk);
			n++;
		end
		if (n >= 5000)
			check(32'h0, 32'h1);
		@(posedge sys_clk);
	endtask

	// 32-bit clamp of the ideal trapezoid sum
	function automatic logic [31:0] sat(input longint v);
		if (v > 64'sh7fff_ffff)
			return 32'h7fff_ffff;
		if (v < -64'sh8000_0000)
			return 32'h8000_0000;
		return v[31:0];
	endfunction

	// constant inputs: every pair sums to twice the sample, dec+1 pairs per period
	task automatic run_case(input logic [15:0] dec, input logic [15:0] s [4]);
		logic [31:0] lo;
		logic [31:0] hi;
		logic [31:0] e;
		time         t0;
		rate_x  <= s[0];
		rate_y  <= s[1];
		rate_z  <= s[2];
		accel_x <= s[3];
		wr(`DAV_IDX_DECIMATION, {16'h0, dec});
		rd(`DAV_IDX_DECIMATION, d);
		check(d, {16'h0, dec});
		wait_done();
		wait_done();
		t0 = $time;
		wait_done();
		check(32'($time - t0), (32'(dec) + 1) * 40);
		for (int i = 0; i < 4; i++) begin
			e = sat(longint'($signed(s[i])) * 2 * (longint'(dec) + 1) * (i < 3 ? 252 : 1));
			rd(8'h24 + 8'(4 * i), lo);
			rd(8'h26 + 8'(4 * i), hi);
			check(hi, {16'h0, e[31:16]});
			check(lo, {16'h0, e[15:0]});
		end
	endtask

	// hang guard, well beyond the longest case
	initial begin
		#200us;
		miscompares++;
		summarize();
	end

	initial begin
		repeat (12) @(posedge sys_clk);
		rst_n <= 1'b1;
		rd(`DAV_IDX_DECIMATION, d);
		check(d, 32'h0);
		wr(`DAV_IDX_X_ANG_LO, 32'h0000_1234);
		rd(`DAV_IDX_X_ANG_LO, d);
		check(d, 32'h0);
		rd(8'hff, d);
		check(d, `DAV_UNMAPPED_READ);
		run_case(16'h0000, '{16'h0064, 16'hfffd, 16'h7fff, 16'h0005});
		run_case(16'h0007, '{16'h8000, 16'h0000, 16'hffff, 16'h7fff});
		run_case(16'h00c7, '{16'h0000, 16'h8000, 16'h7fff, 16'hffff});
		// outside sample clock; two updates so a setting of 0 surely holds
		wr(`DAV_IDX_DECIMATION, 32'h0);
		wait_done();
		wait_done();
		wr(`DAV_IDX_CONTROL, 32'h1);
		rd(`DAV_IDX_CONTROL, d);
		check(d, 32'h1);
		rd(`DAV_IDX_UPDATE_COUNT, c0);
		// each pin rise is one sample and, with a setting of 0, one update
		repeat (4) begin
			ext_sample_pin <= 1'b1;
			repeat (4) @(posedge sys_clk);
			ext_sample_pin <= 1'b0;
			repeat (4) @(posedge sys_clk);
		end
		rd(`DAV_IDX_UPDATE_COUNT, d);
		check(d, {16'h0, c0[15:0] + 16'h0004});
		summarize();
	end
endmodule

bind dav_top dav_top_chk #(.SAMPLE_DIV(SAMPLE_DIV)) dav_top_chk_inst (
	.sys_clk(sys_clk), .rst_n(rst_n), .avs_address(avs_address), .avs_read(avs_read),
	.avs_write(avs_write), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
	.ext_sample_pin(ext_sample_pin), .sample_done_pin(sample_done_pin));
